// [inc/aipfe_regs.svh]
/*
  Register map, field positions, reset values and encodings of the
  converter input front end. Definitions only; included by bare name.
*/
`ifndef AIPFE_REGS_SVH
`define AIPFE_REGS_SVH

// Sample format
`define AIPFE_MANT_W 14
`define AIPFE_EXP_W 3
`define AIPFE_NCHAN 4
`define AIPFE_NPORT 2

// Qualification mode codes
`define AIPFE_MODE_FALL 2'h0
`define AIPFE_MODE_RISE 2'h1
`define AIPFE_MODE_HIGH 2'h2
`define AIPFE_MODE_BLANK 2'h3

// Register byte offsets
`define AIPFE_ADDR_W 8
`define AIPFE_OFS_CFG0 8'h00
`define AIPFE_OFS_CFG1 8'h04
`define AIPFE_OFS_CFG2 8'h08
`define AIPFE_OFS_CFG3 8'h0c
`define AIPFE_OFS_STATUS 8'h10
`define AIPFE_OFS_CNT0 8'h14
`define AIPFE_OFS_CNT1 8'h18
`define AIPFE_OFS_CNT2 8'h1c
`define AIPFE_OFS_CNT3 8'h20
`define AIPFE_OFS_SAMPA 8'h24
`define AIPFE_OFS_SAMPB 8'h28

// Register indices
`define AIPFE_IDX_STATUS 4'h4
`define AIPFE_IDX_CNT0 4'h5
`define AIPFE_IDX_SAMPA 4'h9
`define AIPFE_IDX_SAMPB 4'ha

// Channel configuration fields
`define AIPFE_CFG_W 3
`define AIPFE_CFG_MODE_MSB 1
`define AIPFE_CFG_MODE_LSB 0
`define AIPFE_CFG_SEL_BIT 2
`define AIPFE_CFG_RST 3'h2

// Counters and responses
`define AIPFE_CNT_W 16
`define AIPFE_CNT_ONE 16'h0001
`define AIPFE_RESP_OKAY 2'h0
`define AIPFE_RESP_SLVERR 2'h2
`define AIPFE_DATA_ZERO 32'h0000_0000

`endif

// [inc/aipfe_pkg.sv]
/*
  Types of the converter input front end.
  Assumes aipfe_regs.svh on the include path.
*/
`default_nettype none
`include "aipfe_regs.svh"

package aipfe_pkg;

  // Two's-complement mantissa, unsigned exponent
  typedef logic signed [`AIPFE_MANT_W-1:0] aipfe_mant_t;
  typedef logic [`AIPFE_EXP_W-1:0] aipfe_exp_t;

  typedef enum logic [1:0]
  {
    MODE_FALL = `AIPFE_MODE_FALL,
    MODE_RISE = `AIPFE_MODE_RISE,
    MODE_HIGH = `AIPFE_MODE_HIGH,
    MODE_BLANK = `AIPFE_MODE_BLANK
  } aipfe_mode_e;

  // Write channel states, Gray along idle-addr-resp
  typedef enum logic [1:0]
  {
    WS_IDLE = 2'h0,
    WS_ADDR = 2'h1,
    WS_RESP = 2'h3,
    WS_DATA = 2'h2
  } aipfe_wst_e;

  typedef struct packed
  {
    logic hit;
    logic [3:0] idx;
  } aipfe_dec_s;

endpackage : aipfe_pkg

`default_nettype wire

// [inc/aipfe_chan_if.sv]
/*
  Carrier between the front-end top and one channel qualifier.
  Top drives the routed port sample and mode; qualifier returns result.
*/
`timescale 1ns/10ps
`default_nettype none

interface aipfe_chan_if;
  aipfe_pkg::aipfe_mode_e mode;
  aipfe_pkg::aipfe_mant_t man;
  aipfe_pkg::aipfe_exp_t exp;
  logic en_now;
  logic en_prev;
  logic valid;
  aipfe_pkg::aipfe_mant_t man_o;
  aipfe_pkg::aipfe_exp_t exp_o;

  modport cfg (output mode, man, exp, en_now, en_prev, input valid, man_o, exp_o);
  modport qual (input mode, man, exp, en_now, en_prev, output valid, man_o, exp_o);
endinterface : aipfe_chan_if

`default_nettype wire

// [logic/aipfe_qualify.sv]
/*
  Per-channel enable qualifier: decides on which edge a routed sample
  is taken and blanks it where asked. Inputs are already registered.
*/
`timescale 1ns/10ps
`default_nettype none

module aipfe_qualify (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Routed sample in, qualified sample out
  aipfe_chan_if.qual chan
);

  logic accept;
  logic blank;
  logic valid_r;
  aipfe_pkg::aipfe_mant_t man_r;
  aipfe_pkg::aipfe_exp_t exp_r;

  // Edge decision per mode
  always_comb
  begin
    case (chan.mode)
      aipfe_pkg::MODE_FALL: accept = chan.en_prev & ~chan.en_now;
      aipfe_pkg::MODE_RISE: accept = ~chan.en_prev & chan.en_now;
      aipfe_pkg::MODE_HIGH: accept = chan.en_now;
      default: accept = 1'b1;
    endcase
    blank = (chan.mode == aipfe_pkg::MODE_BLANK) & ~chan.en_now;
  end

  // Strobe one cycle per taken sample
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      valid_r <= 1'b0;
    else
      valid_r <= accept;
  end

  // Sample holds between strobes so nothing new is seen
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      man_r <= '0;
      exp_r <= '0;
    end
    else if (accept)
    begin
      man_r <= blank ? '0 : chan.man;
      exp_r <= blank ? '0 : chan.exp;
    end
  end

  assign chan.valid = valid_r;
  assign chan.man_o = man_r;
  assign chan.exp_o = exp_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fall_take: assert property (
    chan.mode == aipfe_pkg::MODE_FALL && chan.en_prev && !chan.en_now |=> chan.valid)
    else $error("falling edge sample not taken");
  a_rise_take: assert property (
    chan.mode == aipfe_pkg::MODE_RISE && !chan.en_prev && chan.en_now
    |=> chan.valid && chan.man_o == $past(chan.man))
    else $error("rising edge sample not taken");
  a_level_take: assert property (
    chan.mode == aipfe_pkg::MODE_HIGH |=> chan.valid == $past(chan.en_now))
    else $error("level mode strobe wrong");
  a_blank_zero: assert property (
    chan.mode == aipfe_pkg::MODE_BLANK && !chan.en_now
    |=> chan.valid && chan.man_o == '0 && chan.exp_o == '0)
    else $error("blanked sample not zero");
  a_edge_only: assert property (
    (chan.mode == aipfe_pkg::MODE_FALL || chan.mode == aipfe_pkg::MODE_RISE)
    && chan.en_prev == chan.en_now |=> !chan.valid)
    else $error("transition mode took a non-edge");
  a_hold_idle: assert property (
    !chan.valid |-> $stable(chan.man_o) && $stable(chan.exp_o))
    else $error("sample changed without strobe");

  c_fall: cover property (chan.mode == aipfe_pkg::MODE_FALL ##1 chan.valid);
  c_rise: cover property (chan.mode == aipfe_pkg::MODE_RISE ##1 chan.valid);
  c_blank: cover property (chan.mode == aipfe_pkg::MODE_BLANK && !chan.en_now);

endmodule : aipfe_qualify

`default_nettype wire

// [logic/aipfe_top.sv]
/*
  Converter input front end: two sample ports captured on CLK_SYS,
  routed to four channels and qualified by per-channel enable modes.
  Configuration and status over an AXI4-Lite slave. Assumes converter
  outputs are synchronous to CLK_SYS and meet its setup time.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
// Behaviour
// - Each port takes 14-bit mantissa, 3-bit exponent
// - Mantissa two's complement, exponent unsigned
// - Both ports captured on rising device clock
// - Each channel picks port A or B
// - Muxed streams feed up to four channels
// - Per-port enable pin with four modes
// - Level mode takes samples while enable high
// - Falling mode takes first edge after fall
// - Rising mode takes first edge after rise
// - Blank mode zeroes sample while enable low
// - Transition modes take only that one edge
// - Downstream computes every cycle regardless
`timescale 1ns/10ps
`default_nettype none
`include "aipfe_regs.svh"

module aipfe_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic [`AIPFE_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [`AIPFE_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Converter port A
  input wire logic [`AIPFE_MANT_W-1:0] PORT_A_MANT,
  input wire logic [`AIPFE_EXP_W-1:0] PORT_A_EXP,
  input wire logic PORT_A_QUALIFY_PIN,
  // Converter port B
  input wire logic [`AIPFE_MANT_W-1:0] PORT_B_MANT,
  input wire logic [`AIPFE_EXP_W-1:0] PORT_B_EXP,
  input wire logic PORT_B_QUALIFY_PIN,
  // Channel samples
  output logic [`AIPFE_NCHAN-1:0][`AIPFE_MANT_W-1:0] CH_MANT,
  output logic [`AIPFE_NCHAN-1:0][`AIPFE_EXP_W-1:0] CH_EXP,
  output logic [`AIPFE_NCHAN-1:0] CH_VALID,
  output logic CALC_STROBE
);

  // Address decode shared by read and write paths
  function automatic aipfe_pkg::aipfe_dec_s reg_decode(
    input logic [`AIPFE_ADDR_W-1:0] a);
    aipfe_pkg::aipfe_dec_s d;
    d.hit = 1'b1;
    d.idx = a[5:2];
    if (a == `AIPFE_OFS_CFG0) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CFG1) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CFG2) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CFG3) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_STATUS) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CNT0) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CNT1) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CNT2) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_CNT3) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_SAMPA) d.idx = a[5:2];
    else if (a == `AIPFE_OFS_SAMPB) d.idx = a[5:2];
    else d.hit = 1'b0;
    return d;
  endfunction : reg_decode

  // Sign-extended sample view for readback
  function automatic logic [31:0] samp_word(
    input aipfe_pkg::aipfe_mant_t m, input aipfe_pkg::aipfe_exp_t e);
    return {13'h0000, e, {2{m[`AIPFE_MANT_W-1]}}, m};
  endfunction : samp_word

  aipfe_pkg::aipfe_wst_e st_r;
  aipfe_pkg::aipfe_wst_e st_nxt;
  aipfe_pkg::aipfe_dec_s wdec;
  aipfe_pkg::aipfe_dec_s rdec;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [`AIPFE_ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [`AIPFE_NCHAN-1:0][`AIPFE_CFG_W-1:0] cfg_r;
  logic [`AIPFE_NCHAN-1:0][`AIPFE_CNT_W-1:0] cnt_r;
  logic [`AIPFE_NCHAN-1:0] cnt_clr;
  logic [`AIPFE_NPORT-1:0][`AIPFE_MANT_W-1:0] in_man_r;
  logic [`AIPFE_NPORT-1:0][`AIPFE_EXP_W-1:0] in_exp_r;
  logic [`AIPFE_NPORT-1:0] en_r;
  logic [`AIPFE_NPORT-1:0] en_prev_r;
  logic [`AIPFE_NCHAN-1:0] ch_valid;
  logic [31:0] rword;

  aipfe_chan_if ch_if[`AIPFE_NCHAN] ();

  // Port capture on the device clock; exponent taken as wired
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      in_man_r <= '0;
      in_exp_r <= '0;
      en_r <= '0;
      en_prev_r <= '0;
    end
    else
    begin
      in_man_r <= {PORT_B_MANT, PORT_A_MANT};
      in_exp_r <= {PORT_B_EXP, PORT_A_EXP};
      en_r <= {PORT_B_QUALIFY_PIN, PORT_A_QUALIFY_PIN};
      en_prev_r <= en_r;
    end
  end

  // Route each channel to its port; one qualifier per channel
  genvar gi;
  generate
    for (gi = 0; gi < `AIPFE_NCHAN; gi++)
    begin : g_ch
      logic sel;
      assign sel = cfg_r[gi][`AIPFE_CFG_SEL_BIT];
      assign ch_if[gi].mode =
        aipfe_pkg::aipfe_mode_e'(cfg_r[gi][`AIPFE_CFG_MODE_MSB:`AIPFE_CFG_MODE_LSB]);
      assign ch_if[gi].man = sel ? in_man_r[1] : in_man_r[0];
      assign ch_if[gi].exp = sel ? in_exp_r[1] : in_exp_r[0];
      assign ch_if[gi].en_now = sel ? en_r[1] : en_r[0];
      assign ch_if[gi].en_prev = sel ? en_prev_r[1] : en_prev_r[0];
      assign ch_valid[gi] = ch_if[gi].valid;
      assign CH_MANT[gi] = ch_if[gi].man_o;
      assign CH_EXP[gi] = ch_if[gi].exp_o;
      aipfe_qualify u_qual (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .chan(ch_if[gi])
      );
    end
  endgenerate

  assign CH_VALID = ch_valid;

  // Filter engine runs each cycle even when the front end ignores it
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      CALC_STROBE <= 1'b0;
    else
      CALC_STROBE <= 1'b1;
  end

  // Write channel sequencing; address and data in either order
  assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      aipfe_pkg::WS_IDLE:
        if (aw_hs && w_hs) st_nxt = aipfe_pkg::WS_RESP;
        else if (aw_hs) st_nxt = aipfe_pkg::WS_ADDR;
        else if (w_hs) st_nxt = aipfe_pkg::WS_DATA;
      aipfe_pkg::WS_ADDR:
        if (w_hs) st_nxt = aipfe_pkg::WS_RESP;
      aipfe_pkg::WS_DATA:
        if (aw_hs) st_nxt = aipfe_pkg::WS_RESP;
      default:
        if (S_AXI_BVALID && S_AXI_BREADY) st_nxt = aipfe_pkg::WS_IDLE;
    endcase
  end

  // State and registered readies follow the next state
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      st_r <= aipfe_pkg::WS_IDLE;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      S_AXI_AWREADY <= (st_nxt == aipfe_pkg::WS_IDLE) | (st_nxt == aipfe_pkg::WS_DATA);
      S_AXI_WREADY <= (st_nxt == aipfe_pkg::WS_IDLE) | (st_nxt == aipfe_pkg::WS_ADDR);
    end
  end

  // Hold the write payload until the response stage
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      if (aw_hs) waddr_r <= S_AXI_AWADDR;
      if (w_hs) wdata_r <= S_AXI_WDATA;
      if (w_hs) wstrb_r <= S_AXI_WSTRB;
    end
  end

  // Write takes effect one cycle into the response state
  assign wdec = reg_decode(waddr_r);
  assign do_write = (st_r == aipfe_pkg::WS_RESP) & ~S_AXI_BVALID;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `AIPFE_RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wdec.hit ? `AIPFE_RESP_OKAY : `AIPFE_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // Channel configuration, low byte lane only
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      cfg_r <= {`AIPFE_NCHAN{`AIPFE_CFG_RST}};
    else if (do_write && wdec.hit && wstrb_r[0] && wdec.idx < `AIPFE_IDX_STATUS)
      cfg_r[wdec.idx[1:0]] <= wdata_r[`AIPFE_CFG_W-1:0];
  end

  // Sample counters; a sample in the same cycle as a clearing write restarts the count at one
  always_comb
  begin
    cnt_clr = '0;
    if (do_write && wdec.hit && wstrb_r != 4'h0 && wdec.idx >= `AIPFE_IDX_CNT0
        && wdec.idx < `AIPFE_IDX_SAMPA)
      cnt_clr[2'(wdec.idx - `AIPFE_IDX_CNT0)] = 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      cnt_r <= '0;
    else
      for (int i = 0; i < `AIPFE_NCHAN; i++)
        if (cnt_clr[i])
          cnt_r[i] <= ch_valid[i] ? `AIPFE_CNT_ONE : '0;
        else if (ch_valid[i])
          cnt_r[i] <= cnt_r[i] + `AIPFE_CNT_ONE;
  end

  // Read mux
  assign rdec = reg_decode(S_AXI_ARADDR);
  always_comb
  begin
    rword = `AIPFE_DATA_ZERO;
    if (!rdec.hit)
      rword = `AIPFE_DATA_ZERO;
    else if (rdec.idx < `AIPFE_IDX_STATUS)
      rword[`AIPFE_CFG_W-1:0] = cfg_r[rdec.idx[1:0]];
    else if (rdec.idx == `AIPFE_IDX_STATUS)
      rword[`AIPFE_NPORT-1:0] = en_r;
    else if (rdec.idx < `AIPFE_IDX_SAMPA)
      rword[`AIPFE_CNT_W-1:0] = cnt_r[2'(rdec.idx - `AIPFE_IDX_CNT0)];
    else if (rdec.idx == `AIPFE_IDX_SAMPA)
      rword = samp_word(in_man_r[0], in_exp_r[0]);
    else
      rword = samp_word(in_man_r[1], in_exp_r[1]);
  end

  // Read channel: one outstanding read, answer next cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= `AIPFE_DATA_ZERO;
      S_AXI_RRESP <= `AIPFE_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rword;
      S_AXI_RRESP <= rdec.hit ? `AIPFE_RESP_OKAY : `AIPFE_RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
    else if (!S_AXI_RVALID)
      S_AXI_ARREADY <= 1'b1;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_route_sel: assert property (
    CH_VALID[1] && $past(cfg_r[1], 2) == cfg_r[1]
    && cfg_r[1][`AIPFE_CFG_MODE_MSB:`AIPFE_CFG_MODE_LSB] != `AIPFE_MODE_BLANK
    |-> CH_MANT[1] == (cfg_r[1][`AIPFE_CFG_SEL_BIT] ? $past(PORT_B_MANT, 2)
                                                   : $past(PORT_A_MANT, 2)))
    else $error("channel sample not from selected port");
  a_exp_pass: assert property (
    CH_VALID[0] && $past(cfg_r[0], 2) == cfg_r[0] && !cfg_r[0][`AIPFE_CFG_SEL_BIT]
    && $past(PORT_A_QUALIFY_PIN, 2) |-> CH_EXP[0] == $past(PORT_A_EXP, 2))
    else $error("exponent not carried");
  a_cfg_write: assert property (
    $rose(S_AXI_BVALID) && waddr_r == `AIPFE_OFS_CFG2 && wstrb_r[0]
    |-> cfg_r[2] == wdata_r[`AIPFE_CFG_W-1:0])
    else $error("configuration write lost");
  a_calc_run: assert property (
    $past(RST_N) |-> CALC_STROBE)
    else $error("computation strobe stopped");
  a_count_step: assert property (
    CH_VALID[3] && !cnt_clr[3] |=> cnt_r[3] == $past(cnt_r[3]) + `AIPFE_CNT_ONE)
    else $error("sample count missed");
  a_b_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID [*1] ##0 !S_AXI_ARREADY)
    else $error("read answer late");

  c_write: cover property ($rose(S_AXI_BVALID) && S_AXI_BRESP == `AIPFE_RESP_OKAY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);

endmodule : aipfe_top

`default_nettype wire

// [test/aipfe_conv_model.sv]
/*
  Converter model for one sample port: a new sample every div clocks,
  channel-select output toggled with each sample. Assumes clk is the
  device clock and that the bench drives run and div after its edges.
*/
`timescale 1ns/10ps
`default_nettype none

module aipfe_conv_model #(
  parameter logic [13:0] FIRST = 14'h1ff0
) (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] div,
  input wire logic fixed_pt,
  // Converter outputs
  output var logic [13:0] mant,
  output var logic [2:0] exp,
  output var logic sel
);
  logic [3:0] cnt_r;

  // Start values; outputs hold while stopped
  initial
  begin
    cnt_r = 4'h0;
    mant = FIRST;
    exp = 3'h0;
    sel = 1'b0;
  end

  // Sample rate is clk divided by div, up to clk itself, so select edges mark each sample once
  always @(posedge clk)
  begin
    if (run)
    begin
      cnt_r <= (cnt_r >= div - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r >= div - 4'h1)
      begin
        mant <= mant + 14'h0123;
        exp <= fixed_pt ? 3'h0 : exp + 3'h1;
        sel <= ~sel;
      end
    end
  end
endmodule : aipfe_conv_model

`default_nettype wire

// [test/aipfe_top_tb_top.sv]
/*
  Self-checking bench of the converter input front end: AXI4-Lite
  master tasks, two converter models, a reference of the qualifier.
  Assumes aipfe_regs.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "aipfe_regs.svh"

module aipfe_top_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, calc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] a_mant, b_mant, mm;
  logic [2:0] a_exp, b_exp, ee;
  logic a_sel, b_sel, en, ep, vv, p;
  logic [3:0][13:0] ch_mant, m1, m2;
  logic [3:0][2:0] ch_exp, e1, e2;
  logic [3:0] ch_valid, st1, st2;
  logic run = 1'b0;
  logic [3:0] div = 4'h1;
  logic chk_on = 1'b0;
  logic [1:0] prev_en = 2'h0;
  logic [2:0] cfg_m [4] = '{3'h2, 3'h2, 3'h2, 3'h2};
  int cnt_m [4];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  initial
  forever #2 clk_sys = ~clk_sys;

  aipfe_top i_aipfe_top (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PORT_A_MANT(a_mant), .PORT_A_EXP(a_exp), .PORT_A_QUALIFY_PIN(a_sel),
    .PORT_B_MANT(b_mant), .PORT_B_EXP(b_exp), .PORT_B_QUALIFY_PIN(b_sel),
    .CH_MANT(ch_mant), .CH_EXP(ch_exp), .CH_VALID(ch_valid), .CALC_STROBE(calc));

  // Port A reports exponents and starts negative for sign checks; port B is fixed point
  aipfe_conv_model #(.FIRST(14'h3ff0)) i_aipfe_conv_model_a (.clk(clk_sys), .run(run),
    .div(div), .fixed_pt(1'b0), .mant(a_mant), .exp(a_exp), .sel(a_sel));
  aipfe_conv_model #(.FIRST(14'h0a55)) i_aipfe_conv_model_b (.clk(clk_sys), .run(run),
    .div(div), .fixed_pt(1'b1), .mant(b_mant), .exp(b_exp), .sel(b_sel));

  task automatic chk(input string what, input logic [31:0] exp_v, input logic [31:0] got);
    num_checks++;
    if (got !== exp_v)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp_v, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      $display("Error timeout expected 0 seen %0d", cyc);
      print_verdict();
    end
  end

  // Reference qualifier, compared two edges behind the pins
  always @(posedge clk_sys)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (chk_on)
      begin
        chk("ch_valid", 32'(st2[c]), 32'(ch_valid[c]));
        if (st2[c] === 1'b1)
        begin
          cnt_m[c]++;
          chk("ch_mant", 32'(m2[c]), 32'(ch_mant[c]));
          chk("ch_exp", 32'(e2[c]), 32'(ch_exp[c]));
        end
      end
    end
    st2 = st1;
    m2 = m1;
    e2 = e1;
    for (int c = 0; c < 4; c++)
    begin
      p = cfg_m[c][`AIPFE_CFG_SEL_BIT];
      en = p ? b_sel : a_sel;
      ep = prev_en[p];
      mm = p ? b_mant : a_mant;
      ee = p ? b_exp : a_exp;
      case (cfg_m[c][1:0])
        `AIPFE_MODE_FALL: vv = ep & ~en;
        `AIPFE_MODE_RISE: vv = ~ep & en;
        `AIPFE_MODE_HIGH: vv = en;
        default:
        begin
          vv = 1'b1;
          mm = en ? mm : 14'h0000;
          ee = en ? ee : 3'h0;
        end
      endcase
      st1[c] = vv;
      m1[c] = mm;
      e1[c] = ee;
    end
    prev_en = {b_sel, a_sel};
    if (chk_on)
      chk("calc_strobe", 32'h1, 32'(calc));
  end

  // Address and data offered together, released when each is taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
    input logic [3:0] s = 4'hf);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_sys);
      if (awvalid && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk_sys);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
    // One edge apart, so a following call never drives bready twice at one edge
    @(posedge clk_sys);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk_sys);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk_sys);
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
    // One edge apart, so a following call never drives rready twice at one edge
    @(posedge clk_sys);
  endtask : axi_read

  task automatic set_cfg(input int c, input logic [2:0] v);
    axi_write(8'(4 * c), {29'h0, v}, `AIPFE_RESP_OKAY);
    cfg_m[c] = v;
  endtask : set_cfg

  // Masked lane, reset values, unmapped place, read-only place, pin readback
  task automatic t_regs;
    axi_write(`AIPFE_OFS_CFG1, 32'h7, `AIPFE_RESP_OKAY, 4'he);
    for (int c = 0; c < 4; c++)
      axi_read(8'(4 * c), 32'h2, `AIPFE_RESP_OKAY);
    axi_read(`AIPFE_OFS_CNT0, 32'h0, `AIPFE_RESP_OKAY);
    axi_write(8'h40, 32'h5, `AIPFE_RESP_SLVERR);
    axi_read(8'h40, 32'h0, `AIPFE_RESP_SLVERR);
    axi_write(`AIPFE_OFS_SAMPA, 32'hffff_ffff, `AIPFE_RESP_OKAY);
    axi_read(`AIPFE_OFS_SAMPA, {13'h0, a_exp, {2{a_mant[13]}}, a_mant}, 2'h0);
    axi_read(`AIPFE_OFS_SAMPB, {13'h0, b_exp, {2{b_mant[13]}}, b_mant}, 2'h0);
    axi_read(`AIPFE_OFS_STATUS, {30'h0, b_sel, a_sel}, `AIPFE_RESP_OKAY);
  endtask : t_regs

  // Enable toggling every clock; level and blank on both ports
  task automatic t_level_blank;
    set_cfg(0, 3'h2);
    set_cfg(1, 3'h3);
    set_cfg(2, 3'h6);
    set_cfg(3, 3'h7);
    axi_read(`AIPFE_OFS_CFG3, 32'h7, `AIPFE_RESP_OKAY);
    div <= 4'h1;
    repeat (4) @(posedge clk_sys);
    cnt_m = '{0, 0, 0, 0};
    chk_on <= 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge clk_sys);
    run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_on <= 1'b0;
    chk("level strobes a", 32'd20, 32'(cnt_m[0]));
    chk("level strobes b", 32'd20, 32'(cnt_m[2]));
  endtask : t_level_blank

  // Interleaved streams split by opposite edges, clock three times faster
  task automatic t_diversity;
    set_cfg(0, 3'h0);
    set_cfg(1, 3'h1);
    set_cfg(2, 3'h4);
    set_cfg(3, 3'h5);
    for (int c = 0; c < 4; c++)
      axi_write(8'(`AIPFE_OFS_CNT0 + 4 * c), 32'h1, `AIPFE_RESP_OKAY);
    div <= 4'h3;
    repeat (4) @(posedge clk_sys);
    cnt_m = '{0, 0, 0, 0};
    chk_on <= 1'b1;
    run <= 1'b1;
    repeat (60) @(posedge clk_sys);
    run <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_on <= 1'b0;
    for (int c = 0; c < 4; c++)
      chk("edge strobes", 32'd10, 32'(cnt_m[c]));
    for (int c = 0; c < 4; c++)
      axi_read(8'(`AIPFE_OFS_CNT0 + 4 * c), 32'd10, `AIPFE_RESP_OKAY);
  endtask : t_diversity

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_level_blank();
    t_diversity();
    print_verdict();
  end
endmodule : aipfe_top_tb_top

`default_nettype wire
